// ---- src/rxe_pkg.sv ----
package rxe_pkg;

	// ****************************************
	// Register offsets inside one port window
	// ****************************************
	localparam logic [9:0] OFF_SL_STAT   = 10'h1F0;
	localparam logic [9:0] OFF_PD_WC     = 10'h200;
	localparam logic [9:0] OFF_PD_RC     = 10'h204;
	localparam logic [9:0] OFF_PD_RCE    = 10'h208;
	localparam logic [9:0] OFF_PD_MSK    = 10'h20C;
	localparam logic [9:0] OFF_PE_WC     = 10'h210;
	localparam logic [9:0] OFF_PE_RC     = 10'h214;
	localparam logic [9:0] OFF_PE_RCE    = 10'h218;
	localparam logic [9:0] OFF_PE_MSK    = 10'h21C;
	localparam logic [9:0] OFF_PATH_NOW  = 10'h230;
	localparam logic [9:0] OFF_CP_WC     = 10'h240;
	localparam logic [9:0] OFF_CP_RC     = 10'h244;
	localparam logic [9:0] OFF_CP_RCE    = 10'h248;
	localparam logic [9:0] OFF_CP_MSK    = 10'h24C;

	// ****************************************
	// Address split: port select above offset
	// ****************************************
	localparam int         ADDR_W        = 12;
	localparam int         PORT_LSB      = 10;

	// ****************************************
	// Defined bits and reset values
	// ****************************************
	localparam logic [31:0] SL_DEF       = 32'h0000_0EFF;
	localparam logic [31:0] SL_RST       = 32'h0000_0026;
	localparam int          SL_CD_BIT    = 9;
	localparam logic [31:0] PD_DEF       = 32'h01FF_07FF;
	localparam logic [31:0] PD_RST       = 32'h0000_0002;
	localparam logic [31:0] PE_DEF       = 32'h0000_07FF;
	localparam logic [31:0] PE_RST       = 32'h0000_0000;
	localparam logic [31:0] PATH_NOW_RST = 32'h0000_0002;
	localparam logic [31:0] CP_DEF       = 32'h0FFF_0003;
	localparam logic [31:0] CP_RST       = 32'h0000_0003;
	localparam int          PATH_N       = 11;
	localparam int          PULSE_LSB    = 16;

endpackage

// ---- src/rxe_bank_if.sv ----
interface rxe_bank_if;
	logic [31:0] set;
	logic [31:0] wdata;
	logic        wc_wr;
	logic        rc_rd;
	logic        rce_wr;
	logic        msk_wr;
	logic [31:0] flags;
	logic [31:0] rce;
	logic [31:0] msk;
	logic        pend;

	modport bank (
		input  set, wdata, wc_wr, rc_rd, rce_wr, msk_wr,
		output flags, rce, msk, pend
	);
	modport ctl (
		output set, wdata, wc_wr, rc_rd, rce_wr, msk_wr,
		input  flags, rce, msk, pend
	);
endinterface

// ---- src/rxe_sync2.sv ----
module rxe_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// ****************************************
	// Two stages, no reset: the level must
	// follow the pin even while in reset
	// ****************************************
	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule

// ---- src/rxe_flag_bank.sv ----
module rxe_flag_bank #(
	parameter logic [31:0] DEF_BITS = 32'hFFFF_FFFF,
	parameter logic [31:0] FLAG_RST = 32'h0000_0000
) (
	input  wire logic clk,
	input  wire logic rst,
	rxe_bank_if.bank  bus
);
	logic [31:0] clr;

	always_comb begin
		clr = 32'h0000_0000;
		if (bus.wc_wr) begin
			clr = clr | bus.wdata; // RQ17
		end
		if (bus.rc_rd) begin
			clr = clr | bus.rce; // RQ9
		end
	end

	// ****************************************
	// Sticky flags: a new event beats a clear
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.flags <= FLAG_RST;
		end else begin
			bus.flags <= ((bus.flags & ~clr) | bus.set) & DEF_BITS; // RQ17
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus.rce <= DEF_BITS; // RQ9
		end else if (bus.rce_wr) begin
			bus.rce <= bus.wdata & DEF_BITS;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus.msk <= DEF_BITS; // RQ10
		end else if (bus.msk_wr) begin
			bus.msk <= bus.wdata & DEF_BITS;
		end
	end

	assign bus.pend = |(bus.flags & ~bus.msk); // RQ10
endmodule

// ---- src/rxe_events.sv ----
// How it works
// RQ1: live word mirrors active section/line conditions
// RQ2: bit 9 reads 1 while carrier pin low
// RQ3: reset shows line alarm, LOF, OOF active
// RQ4: path defect onsets latch into bits 0-10
// RQ5: B3, REI, justifications latch bits 16-19
// RQ6: counter overflows latch bits 20-23
// RQ7: finished path trace capture sets bit 24
// RQ8: path detect views 0x200/0x204, reset 2
// RQ9: read-clear clears only enabled flags
// RQ10: mask 1 hides flag from interrupt
// RQ11: path defect ends latch, views 0x210/0x214
// RQ12: end flags have enable 0x218, mask 0x21C
// RQ13: path live word at 0x230, reset 2
// RQ14: cell/packet views 0x240/0x244, reset 3
// RQ15: packet errors latch bits 16-20
// RQ16: cell delineation losses latch bits 0-1
// RQ17: write 1 clears; same-cycle event wins
// RQ18: interrupt when unmasked flag is set
module rxe_events #(
	parameter logic [1:0] PORT_SEL = 2'h0
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Processor side
	input  wire logic                    cpu_cs,
	input  wire logic                    cpu_rd,
	input  wire logic                    cpu_wr,
	input  wire logic [rxe_pkg::ADDR_W-1:0] cpu_addr,
	input  wire logic [31:0]             cpu_wdata,
	output logic      [31:0]             cpu_rdata,
	output logic                         cpu_rd_valid,
	output logic                         irq,
	// Carrier detect pin, outside this clock
	input  wire logic                    carrier_detect_pin,
	// Section and line monitor levels
	input  wire logic                    loss_of_signal,
	input  wire logic                    out_of_frame,
	input  wire logic                    loss_of_frame,
	input  wire logic                    section_trace_mismatch,
	input  wire logic                    section_trace_unstable,
	input  wire logic                    line_alarm_indication,
	input  wire logic                    line_remote_defect,
	input  wire logic                    protection_switch_byte_fail,
	input  wire logic                    signal_fail,
	input  wire logic                    signal_degrade,
	// Path monitor levels
	input  wire logic                    loss_of_pointer,
	input  wire logic                    path_alarm_indication,
	input  wire logic                    single_bit_path_rdi,
	input  wire logic                    enh_rdi_server,
	input  wire logic                    enh_rdi_connectivity,
	input  wire logic                    enh_rdi_payload,
	input  wire logic                    path_label_mismatch,
	input  wire logic                    path_unequipped,
	input  wire logic                    path_label_unstable,
	input  wire logic                    path_trace_mismatch,
	input  wire logic                    path_trace_unstable,
	// Path one-cycle event pulses
	input  wire logic                    b3_error_seen,
	input  wire logic                    path_rei_seen,
	input  wire logic                    pos_justify_seen,
	input  wire logic                    neg_justify_seen,
	input  wire logic                    b3_error_count_ovf,
	input  wire logic                    path_rei_count_ovf,
	input  wire logic                    pos_justify_count_ovf,
	input  wire logic                    neg_justify_count_ovf,
	input  wire logic                    path_trace_stored,
	// Cell and packet monitor
	input  wire logic                    out_of_cell_delineation,
	input  wire logic                    loss_cell_delineation,
	input  wire logic                    abort_packet_seen,
	input  wire logic                    address_error_seen,
	input  wire logic                    fcs_error_seen,
	input  wire logic                    short_packet_seen,
	input  wire logic                    long_packet_seen,
	input  wire logic [6:0]              cell_packet_count_ovf
);

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic hit(
		input logic [rxe_pkg::ADDR_W-1:0] a,
		input logic [9:0]                 off
	);
		hit = (a[rxe_pkg::ADDR_W-1:rxe_pkg::PORT_LSB] == PORT_SEL)
			&& (a[rxe_pkg::PORT_LSB-1:0] == off);
	endfunction

	// High now and low at the last sample; swap the
	// arguments to get the end of a condition instead
	function automatic logic [rxe_pkg::PATH_N-1:0] onset(
		input logic [rxe_pkg::PATH_N-1:0] now,
		input logic [rxe_pkg::PATH_N-1:0] last
	);
		onset = now & ~last;
	endfunction

	logic        rd_go;
	logic        wr_go;
	logic        cd_sync;
	logic [31:0] sl_live;
	logic [31:0] path_lvl;
	logic [31:0] sl_stat_r;
	logic [31:0] path_now_r;
	logic [1:0]  cell_lvl_r;
	logic [31:0] rdata_nxt;
	logic        rd_hit;

	rxe_bank_if pd_if ();
	rxe_bank_if pe_if ();
	rxe_bank_if cp_if ();

	assign rd_go = cpu_cs && cpu_rd;
	assign wr_go = cpu_cs && cpu_wr;

	// ****************************************
	// Carrier detect pin crossing
	// ****************************************
	rxe_sync2 #(
		.W (1)
	) u_cd_sync (
		.clk (clk),
		.d   (carrier_detect_pin),
		.q   (cd_sync)
	);

	// ****************************************
	// Live status words
	// ****************************************
	always_comb begin
		sl_live     = 32'h0000_0000;
		sl_live[0]  = loss_of_signal; // RQ1
		sl_live[1]  = out_of_frame;
		sl_live[2]  = loss_of_frame;
		sl_live[3]  = section_trace_mismatch;
		sl_live[4]  = section_trace_unstable;
		sl_live[5]  = line_alarm_indication;
		sl_live[6]  = line_remote_defect;
		sl_live[7]  = protection_switch_byte_fail;
		sl_live[rxe_pkg::SL_CD_BIT] = ~cd_sync; // RQ2
		sl_live[10] = signal_fail;
		sl_live[11] = signal_degrade;
	end

	always_comb begin
		path_lvl     = 32'h0000_0000;
		path_lvl[0]  = loss_of_pointer;
		path_lvl[1]  = path_alarm_indication;
		path_lvl[2]  = single_bit_path_rdi;
		path_lvl[3]  = enh_rdi_server;
		path_lvl[4]  = enh_rdi_connectivity;
		path_lvl[5]  = enh_rdi_payload;
		path_lvl[6]  = path_label_mismatch;
		path_lvl[7]  = path_unequipped;
		path_lvl[8]  = path_label_unstable;
		path_lvl[9]  = path_trace_mismatch;
		path_lvl[10] = path_trace_unstable;
	end

	// Carrier bit follows the pin even in reset
	always_ff @(posedge clk) begin
		if (rst) begin
			sl_stat_r <= rxe_pkg::SL_RST; // RQ3
			sl_stat_r[rxe_pkg::SL_CD_BIT] <= ~cd_sync; // RQ2
		end else begin
			sl_stat_r <= sl_live & rxe_pkg::SL_DEF; // RQ1
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			path_now_r <= rxe_pkg::PATH_NOW_RST; // RQ13
		end else begin
			path_now_r <= path_lvl & rxe_pkg::PE_DEF; // RQ13
		end
	end

	// Reset to active so delineation already lost
	// at reset does not raise a second event
	always_ff @(posedge clk) begin
		if (rst) begin
			cell_lvl_r <= 2'h3;
		end else begin
			cell_lvl_r <= {loss_cell_delineation,
				out_of_cell_delineation};
		end
	end

	// ****************************************
	// Event sources for the three flag banks
	// ****************************************
	always_comb begin
		pd_if.set     = 32'h0000_0000;
		// Onset: live level high, last sample low
		pd_if.set[rxe_pkg::PATH_N-1:0] =
			onset(path_lvl[rxe_pkg::PATH_N-1:0],
				path_now_r[rxe_pkg::PATH_N-1:0]); // RQ4
		// Monitor pulses are one cycle wide already
		pd_if.set[16] = b3_error_seen; // RQ5
		pd_if.set[17] = path_rei_seen;
		pd_if.set[18] = pos_justify_seen;
		pd_if.set[19] = neg_justify_seen;
		pd_if.set[20] = b3_error_count_ovf; // RQ6
		pd_if.set[21] = path_rei_count_ovf;
		pd_if.set[22] = pos_justify_count_ovf;
		pd_if.set[23] = neg_justify_count_ovf;
		pd_if.set[24] = path_trace_stored; // RQ7
	end

	always_comb begin
		pe_if.set = 32'h0000_0000;
		pe_if.set[rxe_pkg::PATH_N-1:0] =
			onset(path_now_r[rxe_pkg::PATH_N-1:0],
				path_lvl[rxe_pkg::PATH_N-1:0]); // RQ11
	end

	always_comb begin
		cp_if.set     = 32'h0000_0000;
		cp_if.set[0]  = out_of_cell_delineation
			& ~cell_lvl_r[0]; // RQ16
		cp_if.set[1]  = loss_cell_delineation
			& ~cell_lvl_r[1]; // RQ16
		cp_if.set[16] = abort_packet_seen; // RQ15
		cp_if.set[17] = address_error_seen;
		cp_if.set[18] = fcs_error_seen;
		cp_if.set[19] = short_packet_seen;
		cp_if.set[20] = long_packet_seen;
		cp_if.set[27:21] = cell_packet_count_ovf; // RQ14
	end

	// ****************************************
	// Bank strobes
	// ****************************************
	assign pd_if.wdata  = cpu_wdata;
	assign pe_if.wdata  = cpu_wdata;
	assign cp_if.wdata  = cpu_wdata;
	// RQ8
	assign pd_if.wc_wr  = wr_go && hit(cpu_addr, rxe_pkg::OFF_PD_WC);
	assign pd_if.rc_rd  = rd_go && hit(cpu_addr, rxe_pkg::OFF_PD_RC);
	assign pd_if.rce_wr = wr_go && hit(cpu_addr, rxe_pkg::OFF_PD_RCE);
	assign pd_if.msk_wr = wr_go && hit(cpu_addr, rxe_pkg::OFF_PD_MSK);
	// RQ11
	assign pe_if.wc_wr  = wr_go && hit(cpu_addr, rxe_pkg::OFF_PE_WC);
	assign pe_if.rc_rd  = rd_go && hit(cpu_addr, rxe_pkg::OFF_PE_RC);
	// RQ12
	assign pe_if.rce_wr = wr_go && hit(cpu_addr, rxe_pkg::OFF_PE_RCE);
	assign pe_if.msk_wr = wr_go && hit(cpu_addr, rxe_pkg::OFF_PE_MSK);
	// RQ14
	assign cp_if.wc_wr  = wr_go && hit(cpu_addr, rxe_pkg::OFF_CP_WC);
	assign cp_if.rc_rd  = rd_go && hit(cpu_addr, rxe_pkg::OFF_CP_RC);
	assign cp_if.rce_wr = wr_go && hit(cpu_addr, rxe_pkg::OFF_CP_RCE);
	assign cp_if.msk_wr = wr_go && hit(cpu_addr, rxe_pkg::OFF_CP_MSK);

	rxe_flag_bank #(
		.DEF_BITS (rxe_pkg::PD_DEF),
		.FLAG_RST (rxe_pkg::PD_RST)
	) u_path_detect (
		.clk (clk),
		.rst (rst),
		.bus (pd_if)
	);

	rxe_flag_bank #(
		.DEF_BITS (rxe_pkg::PE_DEF),
		.FLAG_RST (rxe_pkg::PE_RST)
	) u_path_end (
		.clk (clk),
		.rst (rst),
		.bus (pe_if)
	);

	rxe_flag_bank #(
		.DEF_BITS (rxe_pkg::CP_DEF),
		.FLAG_RST (rxe_pkg::CP_RST)
	) u_cell_packet (
		.clk (clk),
		.rst (rst),
		.bus (cp_if)
	);

	// ****************************************
	// Read mux
	// ****************************************
	// Only this port's window answers: reads for
	// the other three ports leave the valid strobe
	// low, so four blocks can share one read bus
	// The read-clear views return the flags as
	// they stood before the clear takes effect
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		rd_hit    = 1'b1;
		case (cpu_addr[rxe_pkg::PORT_LSB-1:0])
			rxe_pkg::OFF_SL_STAT:  rdata_nxt = sl_stat_r; // RQ1
			rxe_pkg::OFF_PD_WC,
			rxe_pkg::OFF_PD_RC:    rdata_nxt = pd_if.flags; // RQ8
			rxe_pkg::OFF_PD_RCE:   rdata_nxt = pd_if.rce;
			rxe_pkg::OFF_PD_MSK:   rdata_nxt = pd_if.msk;
			rxe_pkg::OFF_PE_WC,
			rxe_pkg::OFF_PE_RC:    rdata_nxt = pe_if.flags; // RQ11
			rxe_pkg::OFF_PE_RCE:   rdata_nxt = pe_if.rce; // RQ12
			rxe_pkg::OFF_PE_MSK:   rdata_nxt = pe_if.msk;
			rxe_pkg::OFF_PATH_NOW: rdata_nxt = path_now_r; // RQ13
			rxe_pkg::OFF_CP_WC,
			rxe_pkg::OFF_CP_RC:    rdata_nxt = cp_if.flags; // RQ14
			rxe_pkg::OFF_CP_RCE:   rdata_nxt = cp_if.rce;
			rxe_pkg::OFF_CP_MSK:   rdata_nxt = cp_if.msk;
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
		if (cpu_addr[rxe_pkg::ADDR_W-1:rxe_pkg::PORT_LSB] != PORT_SEL) begin
			rdata_nxt = 32'h0000_0000;
			rd_hit    = 1'b0;
		end
	end

	// Unmapped reads still answer, with zero,
	// so the processor never waits forever
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_rdata    <= 32'h0000_0000;
			cpu_rd_valid <= 1'b0;
		end else begin
			cpu_rdata    <= rd_go ? rdata_nxt : 32'h0000_0000;
			cpu_rd_valid <= rd_go && rd_hit;
		end
	end

	// ****************************************
	// Interrupt request
	// ****************************************
	// Registered so the request pin never glitches,
	// at the cost of one cycle after the flag
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= pd_if.pend || pe_if.pend || cp_if.pend; // RQ18
		end
	end

endmodule

// ---- verif/rxe_events_props.sv ----
module rxe_events_props (
	input wire logic                        clk,
	input wire logic                        rst,
	input wire logic                        cpu_cs,
	input wire logic                        cpu_rd,
	input wire logic [rxe_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic [31:0]                 cpu_rdata,
	input wire logic                        cpu_rd_valid,
	input wire logic                        irq,
	input wire logic                        carrier_detect_pin,
	input wire logic                        loss_of_pointer,
	input wire logic                        b3_error_seen,
	input wire logic                        neg_justify_count_ovf
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ****************************************
	// Register bus and event capture
	// ****************************************
	sequence rd_at(logic [11:0] a);
		cpu_cs && cpu_rd && cpu_addr == a;
	endsequence
	sequence lop_then(logic [11:0] a);
		$rose(loss_of_pointer) ##1 rd_at(a);
	endsequence

	AST_RD_VALID: assert property (
		cpu_cs && cpu_rd && cpu_addr[11:10] == 2'h0 |=> cpu_rd_valid)
		else $error("read not answered next cycle");
	AST_RD_IDLE: assert property (
		!(cpu_cs && cpu_rd) |=> !cpu_rd_valid && cpu_rdata == 32'h0)
		else $error("read data without a read");
	AST_RST_QUIET: assert property (
		$fell(rst) |-> !irq && !cpu_rd_valid && cpu_rdata == 32'h0)
		else $error("outputs active after reset");
	AST_LOP_FLAG: assert property (lop_then(12'h200) |=> cpu_rdata[0])
		else $error("pointer loss flag missing");
	AST_LOP_NOW: assert property (lop_then(12'h230) |=> cpu_rdata[0])
		else $error("pointer loss live bit missing");
	AST_B3_FLAG: assert property (
		b3_error_seen ##1 rd_at(12'h200) |=> cpu_rdata[16])
		else $error("parity error flag missing");
	AST_OVF_FLAG: assert property (
		neg_justify_count_ovf ##1 rd_at(12'h204) |=> cpu_rdata[23])
		else $error("counter overflow flag missing");
	AST_CD_LOW: assert property (
		!carrier_detect_pin [*4] ##0 rd_at(12'h1F0) |=> cpu_rdata[9])
		else $error("carrier low not reported");
	AST_OTHER_PORT: assert property (
		cpu_cs && cpu_rd && cpu_addr[11:10] != 2'h0 |=> !cpu_rd_valid)
		else $error("read for another port answered");
endmodule

bind rxe_events rxe_events_props u_rxe_events_props (
	.clk(clk), .rst(rst), .cpu_cs(cpu_cs), .cpu_rd(cpu_rd),
	.cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
	.cpu_rd_valid(cpu_rd_valid), .irq(irq),
	.carrier_detect_pin(carrier_detect_pin),
	.loss_of_pointer(loss_of_pointer), .b3_error_seen(b3_error_seen),
	.neg_justify_count_ovf(neg_justify_count_ovf)
);

// ---- verif/rxe_events_bench.sv ----
module rxe_events_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, cs, rd, wr, cd, rd_valid, irq, rq, wq;
	logic [11:0] addr, ck;
	logic [31:0] wdata, rdata, r, r2, cpd, cpe, ccp;
	logic [31:0] pd_r, pe_r, cp_r, pdc_r, pdm_r, pec_r, pem_r, cpc_r, cpm_r;
	logic [9:0]  sl, sl_r;
	logic [10:0] pl, plp_r;
	logic [8:0]  pp;
	logic [1:0]  cl, clp_r;
	logic [2:0]  cds_r;
	logic [32:0] exp_rd_r;
	logic        exp_irq_r;
	logic [11:0] at [16];
	int          num_errors, total_checks, seed, i;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	rxe_events u_rxe_events (
		.clk(clk), .rst(rst), .cpu_cs(cs), .cpu_rd(rd), .cpu_wr(wr),
		.cpu_addr(addr), .cpu_wdata(wdata), .cpu_rdata(rdata),
		.cpu_rd_valid(rd_valid), .irq(irq), .carrier_detect_pin(cd),
		.loss_of_signal(sl[0]), .out_of_frame(sl[1]), .loss_of_frame(sl[2]),
		.section_trace_mismatch(sl[3]), .section_trace_unstable(sl[4]),
		.line_alarm_indication(sl[5]), .line_remote_defect(sl[6]),
		.protection_switch_byte_fail(sl[7]), .signal_fail(sl[8]),
		.signal_degrade(sl[9]), .loss_of_pointer(pl[0]),
		.path_alarm_indication(pl[1]), .single_bit_path_rdi(pl[2]),
		.enh_rdi_server(pl[3]), .enh_rdi_connectivity(pl[4]),
		.enh_rdi_payload(pl[5]), .path_label_mismatch(pl[6]),
		.path_unequipped(pl[7]), .path_label_unstable(pl[8]),
		.path_trace_mismatch(pl[9]), .path_trace_unstable(pl[10]),
		.b3_error_seen(pp[0]), .path_rei_seen(pp[1]),
		.pos_justify_seen(pp[2]), .neg_justify_seen(pp[3]),
		.b3_error_count_ovf(pp[4]), .path_rei_count_ovf(pp[5]),
		.pos_justify_count_ovf(pp[6]), .neg_justify_count_ovf(pp[7]),
		.path_trace_stored(pp[8]), .out_of_cell_delineation(cl[0]),
		.loss_cell_delineation(cl[1]), .abort_packet_seen(ck[0]),
		.address_error_seen(ck[1]), .fcs_error_seen(ck[2]),
		.short_packet_seen(ck[3]), .long_packet_seen(ck[4]),
		.cell_packet_count_ovf(ck[11:5])
	);

	// ****************************************
	// Reference model, one step per clock
	// ****************************************
	function automatic logic [31:0] rv(logic [9:0] o);
		case (o)
			10'h1F0: rv = {20'h0, sl_r[9:8], ~cds_r[2], 1'b0, sl_r[7:0]};
			10'h200, 10'h204: rv = pd_r;
			10'h208: rv = pdc_r;
			10'h20C: rv = pdm_r;
			10'h210, 10'h214: rv = pe_r;
			10'h218: rv = pec_r;
			10'h21C: rv = pem_r;
			10'h230: rv = {21'h0, plp_r};
			10'h240, 10'h244: rv = cp_r;
			10'h248: rv = cpc_r;
			10'h24C: rv = cpm_r;
			default: rv = 32'h0;
		endcase
	endfunction

	always @(posedge clk) begin
		// Carrier pin path is never reset, so it shifts during reset too
		cds_r <= {cds_r[1:0], cd};
		if (rst) begin
			{pd_r, pe_r, cp_r} <= {32'h2, 32'h0, 32'h3};
			{pdc_r, pdm_r, pec_r, pem_r, cpc_r, cpm_r} <= {{2{32'h01FF_07FF}},
				{2{32'h0000_07FF}}, {2{32'h0FFF_0003}}};
			{plp_r, clp_r, sl_r} <= {11'h002, 2'h3, 10'h026};
			{exp_rd_r, exp_irq_r} <= '0;
		end else begin
			rq = cs && rd && addr[11:10] == 2'h0;
			wq = cs && wr && addr[11:10] == 2'h0;
			cpd = (wq && addr[9:0] == 10'h200 ? wdata : 32'h0)
				| (rq && addr[9:0] == 10'h204 ? pdc_r : 32'h0);
			cpe = (wq && addr[9:0] == 10'h210 ? wdata : 32'h0)
				| (rq && addr[9:0] == 10'h214 ? pec_r : 32'h0);
			ccp = (wq && addr[9:0] == 10'h240 ? wdata : 32'h0)
				| (rq && addr[9:0] == 10'h244 ? cpc_r : 32'h0);
			pd_r <= (pd_r & ~cpd) | {7'h0, pp, 5'h0, pl & ~plp_r};
			pe_r <= (pe_r & ~cpe) | {21'h0, ~pl & plp_r};
			cp_r <= (cp_r & ~ccp) | {4'h0, ck, 14'h0, cl & ~clp_r};
			{plp_r, clp_r, sl_r} <= {pl, cl, sl};
			if (wq) begin
				case (addr[9:0])
					10'h208: pdc_r <= wdata & 32'h01FF_07FF;
					10'h20C: pdm_r <= wdata & 32'h01FF_07FF;
					10'h218: pec_r <= wdata & 32'h0000_07FF;
					10'h21C: pem_r <= wdata & 32'h0000_07FF;
					10'h248: cpc_r <= wdata & 32'h0FFF_0003;
					10'h24C: cpm_r <= wdata & 32'h0FFF_0003;
					default: ;
				endcase
			end
			exp_rd_r <= rq ? {1'b1, rv(addr[9:0])} : 33'h0;
			exp_irq_r <= |(pd_r & ~pdm_r) || |(pe_r & ~pem_r)
				|| |(cp_r & ~cpm_r);
		end
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		total_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	always @(negedge clk) begin
		if (!rst) begin
			check({rd_valid, rdata}, exp_rd_r);
			check({32'h0, irq}, {32'h0, exp_irq_r});
		end
	end

	task automatic op(input logic c, input logic r_, input logic w,
		input logic [11:0] a, input logic [31:0] d, input logic [8:0] p,
		input logic [10:0] l);
		@(negedge clk);
		{cs, rd, wr, addr, wdata, pp, pl} <= {c, r_, w, a, d, p, l};
	endtask

	task automatic test_done();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		{cs, rd, wr, addr, wdata, pp, pl, sl, cl, ck} = '0;
		{rst, cd, num_errors, total_checks} = {2'h3, 64'h0};
		seed = 32'hE2218F96;
		at = '{12'h1F0, 12'h200, 12'h204, 12'h208, 12'h20C, 12'h210,
			12'h214, 12'h218, 12'h21C, 12'h230, 12'h240, 12'h244,
			12'h248, 12'h24C, 12'h2FC, 12'h600};
		repeat (12) @(negedge clk);
		rst <= 1'b0;
		for (i = 0; i < 15; i++) op(1, 1, 0, at[i], 0, 0, 0);
		for (i = 0; i < 3; i++) begin
			op(0, 0, 0, 0, 0, 9'h1FF, 11'h001);
			op(1, 1, 0, at[i == 1 ? 9 : i + 1 - i / 2], 0, 0, 0);
			op(1, 1, 0, 12'h214, 0, 0, 0);
		end
		op(1, 0, 1, 12'h200, 32'hFFFF_FFFF, 9'h001, 0);
		op(1, 1, 0, 12'h200, 0, 0, 0);
		for (i = 0; i < 3; i++) op(1, 0, 1, at[4 + 4 * i + (i == 2)], 0, 0, 0);
		for (i = 0; i < 3000; i++) begin
			r = $random(seed);
			r2 = $random(seed);
			sl <= sl ^ (r[6:4] == 3'h0 ? 10'h1 << r[11:8] : 10'h0);
			cl <= cl ^ (r[14:12] == 3'h0 ? {r[15], ~r[15]} : 2'h0);
			ck <= r[19:16] == 4'h0 ? 12'h1 << r[23:20] : 12'h0;
			op(r[24], r[25], r[26], at[r[3:0]],
				$random(seed), r2[3:0] == 4'h0 ? 9'h1 << r2[7:4] : 9'h0,
				pl ^ (r2[10:8] == 3'h0 ? 11'h1 << r2[15:12] : 11'h0));
		end
		op(0, 0, 0, 0, 0, 0, pl);
		{sl, cl, ck} <= '0;
		for (i = 0; i < 2; i++) begin
			cd <= ~cd;
			repeat (6) op(0, 0, 0, 0, 0, 0, pl);
			op(1, 1, 0, 12'h1F0, 0, 0, pl);
		end
		repeat (3) op(0, 0, 0, 0, 0, 0, pl);
		test_done();
	end
endmodule
